// [fsp_cpu_model.sv]
// cpu core model: control writes, store and load instructions
module fsp_cpu_model (
  // clock and eeprom status
  input  wire logic        clk_sys_i,
  input  wire logic        eeprom_write_busy_i,
  // instruction side
  output logic             ctl_we_o,
  output logic [7:0]       ctl_wdata_o,
  output logic             store_o,
  output logic             load_o,
  output logic [15:0]      z_ptr_o,
  output logic [15:0]      r1r0_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ctl_we_o    = 1'b0;
    ctl_wdata_o = 8'h00;
    store_o     = 1'b0;
    load_o      = 1'b0;
    z_ptr_o     = 16'h0000;
    r1r0_o      = 16'h0000;
  end
  // ==========================================================================
  // control write then store after gap cycles; gap 0 issues no store
  task automatic spm(input logic [7:0] cmd, input logic [15:0] z, input logic [15:0] d,
                     input int gap, input bit poll);
    while (poll && eeprom_write_busy_i === 1'b1) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    ctl_we_o    <= 1'b1;
    ctl_wdata_o <= cmd;
    z_ptr_o     <= z;
    r1r0_o      <= d;
    @(posedge clk_sys_i);
    ctl_we_o <= 1'b0;
    if (gap > 0) begin
      repeat (gap - 1) @(posedge clk_sys_i);
      store_o <= 1'b1;
      @(posedge clk_sys_i);
      store_o <= 1'b0;
      // data registers are reused by the core: do not leave the old value around
      r1r0_o <= ~d;
    end
  endtask
  // ==========================================================================
  // lock-set enable then load after gap cycles
  task automatic lpm(input logic [15:0] z, input int gap);
    @(posedge clk_sys_i);
    ctl_we_o    <= 1'b1;
    ctl_wdata_o <= 8'h09;
    z_ptr_o     <= z;
    @(posedge clk_sys_i);
    ctl_we_o <= 1'b0;
    repeat (gap - 1) @(posedge clk_sys_i);
    load_o <= 1'b1;
    @(posedge clk_sys_i);
    load_o <= 1'b0;
  endtask
endmodule

// [fsp_pkg.sv]
// package: constants for the flash self-program sequencer
package fsp_pkg;
  // control register bit positions
  localparam int CTL_EN_POS    = 0;
  localparam int CTL_ERS_POS   = 1;
  localparam int CTL_WRT_POS   = 2;
  localparam int CTL_LCK_POS   = 3;
  localparam int CTL_RRE_POS   = 4;
  localparam int CTL_BUSY_POS  = 6;
  localparam int CTL_IE_POS    = 7;
  // command patterns in the low five bits
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_RRE   = 5'h11;
  // enable windows in cycles
  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam logic [2:0] LOAD_WIN  = 3'h3;
  // geometry: 64-word pages, 128 pages, last 32 pages are no-read-while-write
  localparam int WORD_BITS  = 6;
  localparam int PAGE_BITS  = 7;
  localparam int PAGE_WORDS = 64;
  localparam logic [6:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h60;
  // flash operation time (ns) and cycle count at 250 MHz
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS  = 3700000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  // read-back addresses
  localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] Z_LOCK      = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  // reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM  = 2'b01,
    ST_PROG = 2'b10
  } fsp_state_t;
endpackage

// [fsp_seq.sv]
// module: flash self-programming sequencer, core side
// ==========================================================================
module fsp_seq #(
  parameter int PROG_CYCLES_P = fsp_pkg::PROG_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  // control register write port
  input  wire logic        ctl_we_i,
  input  wire logic [7:0]  ctl_wdata_i,
  // store and load instructions
  input  wire logic        store_i,
  input  wire logic        load_i,
  input  wire logic [15:0] z_ptr_i,
  input  wire logic [15:0] r1r0_i,
  // eeprom interlock, fuses
  input  wire logic        eeprom_write_busy_i,
  input  wire logic        eeprom_write_start_i,
  input  wire logic [7:0]  fuse_low_byte_i,
  input  wire logic [7:0]  fuse_high_byte_i,
  input  wire logic [3:0]  fuse_extended_byte_i,
  // status and results
  output logic [7:0]       selfprog_control_status_o,
  output logic             readback_valid_o,
  output logic [7:0]       readback_data_o,
  output logic             cpu_halt_o,
  output logic             section_read_block_o,
  output logic             irq_o,
  output logic             flash_wr_o,
  output logic             flash_ers_o,
  output logic [6:0]       flash_page_o,
  output logic [5:0]       lock_bits_o
);
  // ==========================================================================
  // state
  typedef struct packed {
    fsp_pkg::fsp_state_t st;
    logic [4:0]  cmd;
    logic        irq_en;
    logic        busy;
    logic        halt;
    logic        wr;
    logic        ers;
    logic [6:0]  page;
    logic [22:0] cnt;
    logic [5:0]  lock;
    logic        rb_v;
    logic [7:0]  rb_d;
    logic        irq;
    logic        loading;
    logic [7:0]  stat;
  } fsp_regs_t;

  fsp_regs_t s_reg;
  fsp_regs_t s_next;

  logic [15:0] buf_mem [fsp_pkg::PAGE_WORDS];
  logic [fsp_pkg::PAGE_WORDS-1:0] buf_used_reg;
  logic [fsp_pkg::PAGE_WORDS-1:0] buf_used_next;
  logic [5:0]  widx;
  logic [6:0]  zpage;
  logic        cmd_ok;
  logic        win_start;
  logic        store_open;
  logic        load_open;
  logic        buf_wr;
  logic        buf_clr;
  logic        ee_busy_q1;
  logic        ee_busy;
  logic        ee_start_q1;
  logic        ee_start;

  assign widx  = z_ptr_i[fsp_pkg::WORD_BITS:1];
  assign zpage = z_ptr_i[fsp_pkg::WORD_BITS+fsp_pkg::PAGE_BITS:fsp_pkg::WORD_BITS+1];

  // ==========================================================================
  // eeprom status arrives from another block, synchronised
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ee_busy_q1  <= 1'b0;
      ee_busy     <= 1'b0;
      ee_start_q1 <= 1'b0;
      ee_start    <= 1'b0;
    end else begin
      ee_busy_q1  <= eeprom_write_busy_i;
      ee_busy     <= ee_busy_q1;
      ee_start_q1 <= eeprom_write_start_i;
      ee_start    <= ee_start_q1;
    end
  end

  // ==========================================================================
  // command accept: only defined patterns, only when idle or armed (not programming) and eeprom quiet
  always_comb begin
    cmd_ok = 1'b0;
    case (ctl_wdata_i[4:0])
      fsp_pkg::CMD_LOAD, fsp_pkg::CMD_ERASE, fsp_pkg::CMD_WRITE,
      fsp_pkg::CMD_LOCK, fsp_pkg::CMD_RRE: cmd_ok = 1'b1;
      default: cmd_ok = 1'b0;
    endcase
  end
  assign win_start = ctl_we_i && cmd_ok && !ee_busy && s_reg.st != fsp_pkg::ST_PROG;

  fsp_window u_store_win (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .start_i   (win_start),
    .stop_i    (store_i && store_open),
    .len_i     (fsp_pkg::STORE_WIN),
    .open_o    (store_open)
  );

  fsp_window u_load_win (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .start_i   (win_start),
    .stop_i    (load_i && load_open),
    .len_i     (fsp_pkg::LOAD_WIN),
    .open_o    (load_open)
  );

  // ==========================================================================
  // sequencer
  always_comb begin
    s_next = s_reg;
    s_next.rb_v = 1'b0;
    buf_wr  = 1'b0;
    buf_clr = 1'b0;
    if (ctl_we_i) begin
      s_next.irq_en = ctl_wdata_i[fsp_pkg::CTL_IE_POS];
    end
    case (s_reg.st)
      fsp_pkg::ST_IDLE: begin
        if (win_start) begin
          s_next.cmd = ctl_wdata_i[4:0];
          s_next.st  = fsp_pkg::ST_ARM;
        end
      end
      fsp_pkg::ST_ARM: begin
        if (ee_busy) begin
          s_next.st = fsp_pkg::ST_IDLE;
        end else if (win_start) begin
          s_next.cmd = ctl_wdata_i[4:0];
        end else if (s_reg.cmd == fsp_pkg::CMD_LOCK && load_i && load_open) begin
          s_next.rb_v = 1'b1;
          s_next.st   = fsp_pkg::ST_IDLE;
          case (z_ptr_i)
            fsp_pkg::Z_LOCK:      s_next.rb_d = {2'b11, s_reg.lock};
            fsp_pkg::Z_FUSE_LOW:  s_next.rb_d = fuse_low_byte_i;
            fsp_pkg::Z_FUSE_HIGH: s_next.rb_d = fuse_high_byte_i;
            fsp_pkg::Z_FUSE_EXT:  s_next.rb_d = {4'hF, fuse_extended_byte_i};
            default:              s_next.rb_d = 8'hFF;
          endcase
        end else if (store_i && store_open) begin
          s_next.st = fsp_pkg::ST_IDLE;
          case (s_reg.cmd)
            fsp_pkg::CMD_LOAD: begin
              buf_wr = !buf_used_reg[widx];
              s_next.busy = 1'b0;
              s_next.loading = 1'b1;
            end
            fsp_pkg::CMD_LOCK: begin
              s_next.lock[5:2] = s_reg.lock[5:2] & r1r0_i[5:2];
            end
            fsp_pkg::CMD_RRE: begin
              s_next.busy = 1'b0;
              buf_clr = 1'b1;
              s_next.loading = 1'b0;
            end
            default: begin
              s_next.st   = fsp_pkg::ST_PROG;
              s_next.page = zpage;
              s_next.cnt  = 23'(PROG_CYCLES_P);
              s_next.wr   = s_reg.cmd == fsp_pkg::CMD_WRITE;
              s_next.ers  = s_reg.cmd == fsp_pkg::CMD_ERASE;
              s_next.halt = zpage >= fsp_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
              s_next.busy = zpage < fsp_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
            end
          endcase
        end else if (!store_open) begin
          s_next.st = fsp_pkg::ST_IDLE;
        end
      end
      fsp_pkg::ST_PROG: begin
        if (s_reg.cnt <= 23'h1) begin
          s_next.st   = fsp_pkg::ST_IDLE;
          s_next.halt = 1'b0;
          s_next.wr   = 1'b0;
          s_next.ers  = 1'b0;
          if (s_reg.wr) begin
            buf_clr = 1'b1;
            s_next.loading = 1'b0;
          end
        end else begin
          s_next.cnt = s_reg.cnt - 23'h1;
        end
      end
      default: s_next.st = fsp_pkg::ST_IDLE;
    endcase
    if (ee_start && s_reg.loading) begin
      buf_clr = 1'b1;
      s_next.loading = 1'b0;
    end
    s_next.irq = s_reg.irq_en && s_next.st != fsp_pkg::ST_ARM && s_next.st != fsp_pkg::ST_PROG;
    // status image is registered so the output comes straight from a flop
    s_next.stat = fsp_pkg::CTL_RESET;
    s_next.stat[fsp_pkg::CTL_IE_POS]   = s_next.irq_en;
    s_next.stat[fsp_pkg::CTL_BUSY_POS] = s_next.busy;
    if (s_next.st != fsp_pkg::ST_IDLE) begin
      s_next.stat[4:0] = s_next.cmd;
    end
  end

  always_comb begin
    buf_used_next = buf_used_reg;
    if (buf_clr) begin
      buf_used_next = '0;
    end else if (buf_wr) begin
      buf_used_next[widx] = 1'b1;
    end
  end

  // buffer words are invalidated by the used map; contents need no reset
  always_ff @(posedge clk_sys_i) begin
    if (buf_wr && !buf_clr) begin
      buf_mem[widx] <= r1r0_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg        <= '0;
      s_reg.lock   <= fsp_pkg::LOCK_RESET;
      s_reg.rb_d   <= 8'hFF;
      buf_used_reg <= '0;
    end else begin
      s_reg        <= s_next;
      buf_used_reg <= buf_used_next;
    end
  end

  // ==========================================================================
  // outputs, all registered
  assign selfprog_control_status_o = s_reg.stat;
  assign readback_valid_o     = s_reg.rb_v;
  assign readback_data_o      = s_reg.rb_d;
  assign cpu_halt_o           = s_reg.halt;
  assign section_read_block_o = s_reg.busy;
  assign irq_o                = s_reg.irq;
  assign flash_wr_o           = s_reg.wr;
  assign flash_ers_o          = s_reg.ers;
  assign flash_page_o         = s_reg.page;
  assign lock_bits_o          = s_reg.lock;

  // ==========================================================================
  // checks
  sequence prog_start_s;
    s_reg.st == fsp_pkg::ST_ARM && store_i && store_open && s_reg.cmd == fsp_pkg::CMD_WRITE;
  endsequence

  page_latch_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    prog_start_s |=> flash_page_o == $past(zpage))
    else $error("page not latched");
  wr_enable_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    prog_start_s |=> flash_wr_o && selfprog_control_status_o[0])
    else $error("enable not held in write");
  irq_level_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (s_reg.irq_en && s_reg.st == fsp_pkg::ST_IDLE && !win_start) |=> irq_o)
    else $error("irq not asserted");
  bad_cmd_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (s_reg.st == fsp_pkg::ST_IDLE && ctl_we_i && !cmd_ok) |=> s_reg.st == fsp_pkg::ST_IDLE)
    else $error("undefined command accepted");
  ee_refuse_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (ee_busy && s_reg.st == fsp_pkg::ST_IDLE) |=> s_reg.st == fsp_pkg::ST_IDLE)
    else $error("operation during eeprom write");
  win_close_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (s_reg.st == fsp_pkg::ST_IDLE && win_start) ##1 (!store_i && !load_i && !win_start)[*5]
    |=> s_reg.st == fsp_pkg::ST_IDLE)
    else $error("window not closed");
  dup_load_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    buf_wr |-> !buf_used_reg[widx])
    else $error("buffer word loaded twice");
  ee_discard_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (ee_start && s_reg.loading) |=> buf_used_reg == '0)
    else $error("buffer kept after eeprom write");
  lock_prog_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (s_reg.st == fsp_pkg::ST_ARM && s_reg.cmd == fsp_pkg::CMD_LOCK && store_i && store_open && !ee_busy
     && !win_start && !load_i) |=> lock_bits_o[5:2] == ($past(s_reg.lock[5:2]) & $past(r1r0_i[5:2])))
    else $error("lock bits wrong");
  busy_block_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (s_reg.st == fsp_pkg::ST_PROG && !s_reg.halt) |-> section_read_block_o)
    else $error("section not blocked");
endmodule

// [fsp_seq_tb.sv]
// testbench for the flash self-program sequencer
module fsp_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG_P = 8;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, ee_busy = 1'b0, ee_start = 1'b0;
  logic ctl_we, store, load, rb_valid, halt, block, irq, wr, ers, got;
  logic [7:0] wdata, status, rb_data, q;
  logic [15:0] z, r1r0;
  logic [6:0] page;
  logic [5:0] locks;
  int num_errors = 0, check_count = 0, cycles = 0;
  logic [15:0] zt [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003};
  logic [7:0] et [4] = '{8'hA5, 8'h3F, 8'h09, 8'h3C};
  logic [7:0] mt [4] = '{8'hFF, 8'h3F, 8'h0F, 8'hFF};
  always #2 clk_sys_i = ~clk_sys_i;
  fsp_cpu_model cpu (.clk_sys_i(clk_sys_i), .eeprom_write_busy_i(ee_busy), .ctl_we_o(ctl_we),
    .ctl_wdata_o(wdata), .store_o(store), .load_o(load), .z_ptr_o(z), .r1r0_o(r1r0));
  fsp_seq #(.PROG_CYCLES_P(PROG_P)) DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ctl_we_i(ctl_we),
    .ctl_wdata_i(wdata), .store_i(store), .load_i(load), .z_ptr_i(z), .r1r0_i(r1r0),
    .eeprom_write_busy_i(ee_busy), .eeprom_write_start_i(ee_start), .fuse_low_byte_i(8'hA5),
    .fuse_high_byte_i(8'h3C), .fuse_extended_byte_i(4'h9), .selfprog_control_status_o(status),
    .readback_valid_o(rb_valid), .readback_data_o(rb_data), .cpu_halt_o(halt),
    .section_read_block_o(block), .irq_o(irq), .flash_wr_o(wr), .flash_ers_o(ers),
    .flash_page_o(page), .lock_bits_o(locks));
  // ==========================================================================
  // checking and reporting
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watch three cycles for a read-back pulse
  task automatic grab();
    got = 1'b0;
    q = 8'h00;
    repeat (3) begin
      #1;
      if (rb_valid === 1'b1) begin
        got = 1'b1;
        q = rb_data;
      end
      @(posedge clk_sys_i);
    end
  endtask
  task automatic settle();
    @(posedge clk_sys_i);
    #1;
  endtask
  // a hang must not pass for a quiet run
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("[FAIL] run time expected under 3000 cycles");
      test_done();
    end
  end
  // ==========================================================================
  // tests
  initial begin
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    #1;
    chk("reset status", status, 8'h00);
    chk("reset outputs", {rb_data, locks}, {8'hFF, 6'h3F});
    chk("reset flags", {3'h0, halt, block, irq, wr, ers}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cpu.lpm(zt[i], 1);
      grab();
      chk("read valid", {7'h0, got}, 8'h01);
      chk("read data", q & mt[i], et[i]);
      chk("status after read", status, 8'h00);
    end
    $display("test readback done");
    cpu.spm(8'h09, 16'h0001, 16'hFFD7, 1, 1);
    settle();
    chk("lock bits", {2'b00, locks}, 8'h17);
    cpu.lpm(16'h0001, 1);
    grab();
    chk("lock readback", q & 8'h3F, 8'h17);
    $display("test lock program done");
    cpu.spm(8'h09, 16'h0001, 16'h0000, 0, 1);
    #1;
    chk("armed status", status, 8'h09);
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk("window closed", status, 8'h00);
    cpu.lpm(16'h0001, 5);
    grab();
    chk("late load", {7'h0, got}, 8'h00);
    cpu.spm(8'h07, 16'h0000, 16'h0000, 0, 1);
    #1;
    chk("bad pattern", status, 8'h00);
    $display("test windows done");
    cpu.spm(8'h85, {2'b00, 7'h10, 7'h00}, 16'h1234, 1, 1);
    settle();
    chk("rww write", {wr, ers, halt, block, irq, status[0], status[6], status[7]}, 8'h97);
    cpu.spm(8'h81, 16'hFFFE, 16'h5555, 1, 1);
    #1;
    chk("latched page", {1'b0, page}, 8'h10);
    chk("refused in op", {3'h0, status[4:0]}, 8'h05);
    repeat (PROG_P + 4) @(posedge clk_sys_i);
    #1;
    chk("write finished", {4'h0, wr, status[0], irq, block}, 8'h03);
    settle();
    chk("irq held", {7'h0, irq}, 8'h01);
    cpu.spm(8'h91, 16'h0000, 16'h0000, 1, 1);
    settle();
    chk("busy cleared", {6'h0, block, status[6]}, 8'h00);
    $display("test rww write done");
    for (int k = 0; k < 2; k++) begin
      cpu.spm(k == 0 ? 8'h05 : 8'h03, {2'b00, 7'h70, 7'h00}, 16'h0000, 1, 1);
      settle();
      chk("no_read_while_write_section op", {1'b0, page}, 8'h70);
      chk("no_read_while_write_section flags", {5'h0, wr, ers, halt}, k == 0 ? 8'h05 : 8'h03);
      repeat (PROG_P + 4) @(posedge clk_sys_i);
      cpu.spm(8'h11, 16'h0000, 16'h0000, 1, 1);
    end
    $display("test no_read_while_write_section ops done");
    ee_busy <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    cpu.lpm(16'h0000, 1);
    grab();
    chk("read in eeprom write", {7'h0, got}, 8'h00);
    cpu.spm(8'h05, {2'b00, 7'h10, 7'h00}, 16'h0000, 1, 0);
    settle();
    chk("write in eeprom write", {6'h0, wr, status[0]}, 8'h00);
    ee_busy <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    cpu.spm(8'h01, 16'h0002, 16'hBEEF, 1, 1);
    ee_start <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    ee_start <= 1'b0;
    #1;
    chk("after load", status, 8'h00);
    $display("test eeprom interlock done");
    repeat (4) @(posedge clk_sys_i);
    test_done();
  end
endmodule

// [fsp_window.sv]
// module: countdown window for a timed enable
module fsp_window (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // control
  input  wire logic       start_i,
  input  wire logic       stop_i,
  input  wire logic [2:0] len_i,
  // status
  output logic            open_o
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (start_i) begin
      cnt_next = len_i;
    end else if (stop_i) begin
      cnt_next = 3'h0;
    end else if (cnt_reg != 3'h0) begin
      cnt_next = cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign open_o = (cnt_reg != 3'h0);
endmodule
